/* File: hw/cid_detect_ctrl.sv */
// Purpose: control and flag logic of the caller-identity receive unit
// Assumes: analog detector outputs are synchronous to core_clk
// Notes: registers sit behind a select/strobe port, read data one cycle late
// Function
// - fsk decoder, alert detector, tone receiver each have own enable bit
// - a global enable gates all three detectors on top of their enables
// - ring detection stays active regardless of any enable bit
// - ring envelope rising edge sets ring flag bit 0, raising common flag
// - raw alert rise clears guard timer and counts up on 0.858 ms ticks
// - timer equal to present guard stops it and raises qualified alert
// - raw alert fall runs same timer against absent guard, then releases
// - qualified alert status is driven by hardware only
// - qualified alert rise sets alert flag; only software clears it
// - dual tone uses same guard method with its own guard registers
// - valid dual tone sets decoded status and stores key in bits 0-3
// - decoded status rise sets tone flag; software clears it
// - second config bit 4 turns the tone receiver into a band detector
// - band detector raises high or low group bit at once, no guard
// - carrier bit sets after 8 ms energy, releases after over 8 ms none
// - demodulated bit and its bit clock are readable status bits
// - each full received byte loads the fsk byte and sets byte ready
// - byte ready rise sets byte flag; software clears it
// - rising address bit 4 latches gain data into the addressed register
// - internal addresses 0 to 5 select the six configuration registers
// - config bits 5 and 6 steer tone present reset and absent counting
`timescale 1ns/1ps
module cid_detect_ctrl #(
  parameter int TICK_CYCLES = cid_pkg::GUARD_TICK_CYCLES,
  parameter int CARRIER_CYC = cid_pkg::CARRIER_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register port
  input wire logic [cid_pkg::SEL_W-1:0] sfrSel,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  input wire logic [cid_pkg::DATA_W-1:0] sfrWdata,
  output logic [cid_pkg::DATA_W-1:0] sfrRdata,
  // detector inputs
  input wire logic ringEnvelope,
  input wire logic alertRawDetect,
  input wire logic toneRawDetect,
  input wire logic [cid_pkg::KEY_W-1:0] toneKey,
  input wire logic toneFreqChange,
  input wire logic lowBandEnergy,
  input wire logic highBandEnergy,
  input wire logic fskEnergy,
  input wire logic fskBitIn,
  input wire logic fskBitClkIn,
  // detector enables
  output logic fskDecoderEnable,
  output logic alertDetectEnable,
  output logic dualToneRxEnable,
  // common flag
  output logic callerCommonFlag,
  // internal configuration registers
  output logic [cid_pkg::DATA_W-1:0] toneRxConfigOne,
  output logic [cid_pkg::DATA_W-1:0] toneRxConfigTwo,
  output logic [cid_pkg::DATA_W-1:0] alertFskGain,
  output logic [cid_pkg::DATA_W-1:0] dualToneGain,
  output logic [cid_pkg::DATA_W-1:0] alertToneHysteresis,
  output logic [cid_pkg::DATA_W-1:0] fskFilterHysteresis
);
  import cid_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYCLES);
  localparam int CAR_W = $clog2(CARRIER_CYC + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam logic [CAR_W-1:0] CAR_SET = CAR_W'(CARRIER_CYC - 1);
  localparam logic [CAR_W-1:0] CAR_REL = CAR_W'(CARRIER_CYC);

  logic [EN_W-1:0] enableBits;
  logic fskActive;
  logic alertActive;
  logic toneActive;
  logic toneDetMode;
  logic [TICK_W-1:0] tickCnt;
  logic guardTick;
  logic [GUARD_W-1:0] alertPresentGuard;
  logic [GUARD_W-1:0] alertAbsentGuard;
  logic [GUARD_W-1:0] tonePresentGuard;
  logic [GUARD_W-1:0] toneAbsentGuard;
  logic ringPrev;
  logic alertQualified;
  logic alertPrev;
  logic toneDecoded;
  logic tonePrev;
  logic [KEY_W-1:0] toneKeyReg;
  logic lowGroupPresent;
  logic highGroupPresent;
  logic carrierDetected;
  logic [CAR_W-1:0] carCnt;
  logic demodSerialBit;
  logic demodBitClock;
  logic inFrame;
  logic [BITCNT_W-1:0] bitCount;
  logic [DATA_W-1:0] shiftReg;
  logic [DATA_W-1:0] fskByteRegister;
  logic byteSet;
  logic byteReady;
  logic bytePrev;
  logic [FL_W-1:0] flags;
  logic [FL_W-1:0] flagSet;
  logic [DATA_W-1:0] gainPortAddress;
  logic [DATA_W-1:0] gainPortData;
  logic [DATA_W-1:0] cfgRegs [NUM_INT];
  logic gainStrobe;
  logic [DATA_W-1:0] next_rdata;

  function automatic logic wr(input logic [SEL_W-1:0] sel);
    return sfrWrite && (sfrSel == sel);
  endfunction

  // enables
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      enableBits <= '0;
    end else if (wr(SEL_FSK_BYTE)) begin
      enableBits <= sfrWdata[EN_W-1:0];
    end
  end

  assign fskActive = enableBits[EN_GLOBAL] && enableBits[EN_FSK];
  assign alertActive = enableBits[EN_GLOBAL] && enableBits[EN_ALERT];
  assign toneActive = enableBits[EN_GLOBAL] && enableBits[EN_TONE];
  assign fskDecoderEnable = fskActive;
  assign alertDetectEnable = alertActive;
  assign dualToneRxEnable = toneActive;
  assign toneDetMode = cfgRegs[IDX_CFG2][CFG2_TONE_MODE];

  // guard period tick
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tickCnt <= '0;
    end else if (tickCnt == TICK_LAST) begin
      tickCnt <= '0;
    end else begin
      tickCnt <= tickCnt + 1'h1;
    end
  end

  assign guardTick = (tickCnt == TICK_LAST);

  // guard limit registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      alertPresentGuard <= RESET_BYTE;
      alertAbsentGuard <= RESET_BYTE;
      tonePresentGuard <= RESET_BYTE;
      toneAbsentGuard <= RESET_BYTE;
    end else begin
      if (wr(SEL_ALERT_PT)) alertPresentGuard <= sfrWdata;
      if (wr(SEL_ALERT_AT)) alertAbsentGuard <= sfrWdata;
      if (wr(SEL_TONE_PT)) tonePresentGuard <= sfrWdata;
      if (wr(SEL_TONE_AT)) toneAbsentGuard <= sfrWdata;
    end
  end

  cid_guard_timer #(.W(GUARD_W)) alertGuard (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .enable(alertActive),
    .tick(guardTick),
    .raw(alertRawDetect),
    .freqChange(1'h0),
    .resetOnChange(1'h0),
    .absentPause(1'h1),
    .presentLimit(alertPresentGuard),
    .absentLimit(alertAbsentGuard),
    .qualified(alertQualified)
  );

  cid_guard_timer #(.W(GUARD_W)) toneGuard (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .enable(toneActive && !toneDetMode),
    .tick(guardTick),
    .raw(toneRawDetect),
    .freqChange(toneFreqChange),
    .resetOnChange(cfgRegs[IDX_CFG2][CFG2_CHG_RESET]),
    .absentPause(cfgRegs[IDX_CFG2][CFG2_ABS_PAUSE]),
    .presentLimit(tonePresentGuard),
    .absentLimit(toneAbsentGuard),
    .qualified(toneDecoded)
  );

  // edge history for flag setting; ring path has no enable
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ringPrev <= 1'h0;
      alertPrev <= 1'h0;
      tonePrev <= 1'h0;
      bytePrev <= 1'h0;
    end else begin
      ringPrev <= ringEnvelope;
      alertPrev <= alertQualified;
      tonePrev <= toneDecoded;
      bytePrev <= byteReady;
    end
  end

  // key capture and band detector
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      toneKeyReg <= '0;
      lowGroupPresent <= 1'h0;
      highGroupPresent <= 1'h0;
    end else begin
      if (toneDecoded && !tonePrev) begin
        toneKeyReg <= toneKey;
      end
      lowGroupPresent <= toneActive && toneDetMode && lowBandEnergy;
      highGroupPresent <= toneActive && toneDetMode && highBandEnergy;
    end
  end

  // carrier detect, release hold one cycle longer than set hold
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      carrierDetected <= 1'h0;
      carCnt <= '0;
    end else if (!fskActive) begin
      carrierDetected <= 1'h0;
      carCnt <= '0;
    end else if (fskEnergy == carrierDetected) begin
      carCnt <= '0;
    end else if (carCnt == (carrierDetected ? CAR_REL : CAR_SET)) begin
      carrierDetected <= fskEnergy;
      carCnt <= '0;
    end else begin
      carCnt <= carCnt + 1'h1;
    end
  end

  // demodulated bit stream, start bit then eight bits lsb first
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      demodSerialBit <= 1'h0;
      demodBitClock <= 1'h0;
    end else begin
      demodSerialBit <= fskActive && fskBitIn;
      demodBitClock <= fskActive && fskBitClkIn;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      inFrame <= 1'h0;
      bitCount <= '0;
      shiftReg <= RESET_BYTE;
      fskByteRegister <= RESET_BYTE;
      byteSet <= 1'h0;
    end else begin
      byteSet <= 1'h0;
      if (!fskActive) begin
        inFrame <= 1'h0;
      end else if (fskBitClkIn && !demodBitClock) begin
        if (!inFrame) begin
          inFrame <= !fskBitIn;
          bitCount <= '0;
        end else begin
          shiftReg <= {fskBitIn, shiftReg[DATA_W-1:1]};
          bitCount <= bitCount + 1'h1;
          if (bitCount == LAST_BIT) begin
            fskByteRegister <= {fskBitIn, shiftReg[DATA_W-1:1]};
            byteSet <= 1'h1;
            inFrame <= 1'h0;
          end
        end
      end
    end
  end

  // byte ready holds until the byte is read; a new byte wins
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      byteReady <= 1'h0;
    end else if (byteSet) begin
      byteReady <= 1'h1;
    end else if (sfrRead && sfrSel == SEL_FSK_BYTE) begin
      byteReady <= 1'h0;
    end
  end

  // flags: write zero clears, a same-cycle set wins
  always_comb begin
    flagSet = '0;
    flagSet[FL_RING] = ringEnvelope && !ringPrev;
    flagSet[FL_ALERT] = alertQualified && !alertPrev;
    flagSet[FL_TONE] = toneDecoded && !tonePrev;
    flagSet[FL_BYTE] = byteReady && !bytePrev;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags <= '0;
    end else if (wr(SEL_FLAGS)) begin
      flags <= (flags & sfrWdata[FL_W-1:0]) | flagSet;
    end else begin
      flags <= flags | flagSet;
    end
  end

  assign callerCommonFlag = |flags;

  // indirect gain port
  assign gainStrobe = wr(SEL_GAIN_ADDR) && sfrWdata[GA_STROBE]
    && !gainPortAddress[GA_STROBE];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gainPortAddress <= RESET_BYTE;
      gainPortData <= RESET_BYTE;
    end else begin
      if (wr(SEL_GAIN_ADDR)) gainPortAddress <= sfrWdata;
      if (wr(SEL_GAIN_DATA)) gainPortData <= sfrWdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_INT; i++) begin
        cfgRegs[i] <= RESET_BYTE;
      end
    end else if (gainStrobe) begin
      for (int i = 0; i < NUM_INT; i++) begin
        if (sfrWdata[GA_ADDR_W-1:0] == GA_ADDR_W'(i)) begin
          cfgRegs[i] <= gainPortData;
        end
      end
    end
  end

  assign toneRxConfigOne = cfgRegs[IDX_CFG1];
  assign toneRxConfigTwo = cfgRegs[IDX_CFG2];
  assign alertFskGain = cfgRegs[IDX_ALERT_FSK_GAIN];
  assign dualToneGain = cfgRegs[IDX_DUAL_TONE_GAIN];
  assign alertToneHysteresis = cfgRegs[IDX_ALERT_TONE_HYSTERESIS];
  assign fskFilterHysteresis = cfgRegs[IDX_FSK_FILTER_HYSTERESIS];

  // read mux; status and result bits ignore writes
  always_comb begin
    next_rdata = RESET_BYTE;
    unique case (sfrSel)
      SEL_FSK_BYTE: next_rdata = fskByteRegister;
      SEL_FLAGS: begin
        next_rdata[FL_W-1:0] = flags;
        next_rdata[FL_COMMON] = callerCommonFlag;
      end
      SEL_STATUS: begin
        next_rdata[ST_CARRIER] = carrierDetected;
        next_rdata[ST_SERIAL] = demodSerialBit;
        next_rdata[ST_BITCLK] = demodBitClock;
        next_rdata[ST_BYTE_READY] = byteReady;
        next_rdata[ST_ALERT] = alertQualified;
        next_rdata[ST_TONE] = toneDecoded;
      end
      SEL_TONE_RESULT: begin
        next_rdata[KEY_W-1:0] = toneKeyReg;
        next_rdata[TR_LOW] = lowGroupPresent;
        next_rdata[TR_HIGH] = highGroupPresent;
      end
      SEL_GAIN_ADDR: next_rdata = gainPortAddress;
      SEL_GAIN_DATA: next_rdata = gainPortData;
      SEL_ALERT_PT: next_rdata = alertPresentGuard;
      SEL_ALERT_AT: next_rdata = alertAbsentGuard;
      SEL_TONE_PT: next_rdata = tonePresentGuard;
      SEL_TONE_AT: next_rdata = toneAbsentGuard;
      default: next_rdata = RESET_BYTE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sfrRdata <= RESET_BYTE;
    end else begin
      sfrRdata <= next_rdata;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence phadStrobe;
    gainStrobe && sfrWdata[GA_ADDR_W-1:0] == IDX_ALERT_TONE_HYSTERESIS;
  endsequence

  ring_flag_a: assert property (
    $rose(ringEnvelope) |=> flags[FL_RING] && callerCommonFlag)
    else $error("ring edge did not set the ring flag");
  alert_flag_a: assert property (
    $rose(alertQualified) |=> flags[FL_ALERT])
    else $error("qualified alert did not set its flag");
  tone_flag_a: assert property (
    $rose(toneDecoded) |=> flags[FL_TONE] && toneKeyReg == $past(toneKey))
    else $error("decoded tone flag or key missing");
  byte_flag_a: assert property (
    $rose(byteReady) |=> flags[FL_BYTE])
    else $error("byte ready did not set its flag");
  flag_hold_a: assert property (
    flags[FL_RING] && !wr(SEL_FLAGS) |=> flags[FL_RING] && callerCommonFlag)
    else $error("ring flag dropped without a clear");
  gain_latch_a: assert property (
    phadStrobe |=> alertToneHysteresis == $past(gainPortData))
    else $error("gain strobe did not load the hysteresis register");
  carrier_set_a: assert property (
    $rose(carrierDetected) |-> $past(carCnt) == CAR_SET && $past(fskEnergy))
    else $error("carrier set before its hold time");
  band_detect_a: assert property (
    toneActive && toneDetMode && lowBandEnergy |=> lowGroupPresent)
    else $error("low group bit did not follow band energy");
  fsk_gate_a: assert property (
    !enableBits[EN_GLOBAL] |=> !carrierDetected && !inFrame)
    else $error("fsk decoder ran with the global enable low");
endmodule

/* File: hw/cid_pkg.sv */
// Purpose: shared constants and types of the caller-identity control block
// Assumes: core clock of 25 MHz
// Notes: select codes address the block's special function register port
package cid_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int GUARD_TICK_NS = 858000;
  localparam int GUARD_TICK_CYCLES = GUARD_TICK_NS / CLK_PERIOD_NS;
  localparam int CARRIER_HOLD_NS = 8000000;
  localparam int CARRIER_CYCLES =
    (CARRIER_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // widths
  localparam int DATA_W = 8;
  localparam int SEL_W = 4;
  localparam int GUARD_W = 8;
  localparam int KEY_W = 4;
  localparam int BITCNT_W = 3;
  localparam logic [BITCNT_W-1:0] LAST_BIT = 3'h7;
  localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
  // register select codes
  localparam logic [SEL_W-1:0] SEL_FSK_BYTE = 4'h0;
  localparam logic [SEL_W-1:0] SEL_FLAGS = 4'h1;
  localparam logic [SEL_W-1:0] SEL_STATUS = 4'h2;
  localparam logic [SEL_W-1:0] SEL_TONE_RESULT = 4'h3;
  localparam logic [SEL_W-1:0] SEL_GAIN_ADDR = 4'h4;
  localparam logic [SEL_W-1:0] SEL_GAIN_DATA = 4'h5;
  localparam logic [SEL_W-1:0] SEL_ALERT_PT = 4'h6;
  localparam logic [SEL_W-1:0] SEL_ALERT_AT = 4'h7;
  localparam logic [SEL_W-1:0] SEL_TONE_PT = 4'h8;
  localparam logic [SEL_W-1:0] SEL_TONE_AT = 4'h9;
  // enable bits, written through the fsk byte register
  localparam int EN_FSK = 0;
  localparam int EN_ALERT = 1;
  localparam int EN_TONE = 2;
  localparam int EN_GLOBAL = 3;
  localparam int EN_W = 4;
  // flag bits
  localparam int FL_RING = 0;
  localparam int FL_ALERT = 1;
  localparam int FL_TONE = 2;
  localparam int FL_BYTE = 3;
  localparam int FL_COMMON = 7;
  localparam int FL_W = 4;
  // status bits
  localparam int ST_CARRIER = 0;
  localparam int ST_SERIAL = 1;
  localparam int ST_BITCLK = 2;
  localparam int ST_BYTE_READY = 3;
  localparam int ST_ALERT = 4;
  localparam int ST_TONE = 5;
  // tone result bits above the key
  localparam int TR_LOW = 4;
  localparam int TR_HIGH = 5;
  // gain port
  localparam int GA_ADDR_W = 3;
  localparam int GA_STROBE = 4;
  localparam int NUM_INT = 6;
  localparam logic [GA_ADDR_W-1:0] IDX_CFG1 = 3'h0;
  localparam logic [GA_ADDR_W-1:0] IDX_CFG2 = 3'h1;
  localparam logic [GA_ADDR_W-1:0] IDX_ALERT_FSK_GAIN = 3'h2;
  localparam logic [GA_ADDR_W-1:0] IDX_DUAL_TONE_GAIN = 3'h3;
  localparam logic [GA_ADDR_W-1:0] IDX_ALERT_TONE_HYSTERESIS = 3'h4;
  localparam logic [GA_ADDR_W-1:0] IDX_FSK_FILTER_HYSTERESIS = 3'h5;
  // second tone configuration bits
  localparam int CFG2_TONE_MODE = 4;
  localparam int CFG2_CHG_RESET = 5;
  localparam int CFG2_ABS_PAUSE = 6;
  // guard timer states, gray along idle-present-hold-absent
  typedef enum logic [1:0] {
    GT_IDLE = 2'h0,
    GT_PRESENT = 2'h1,
    GT_HOLD = 2'h3,
    GT_ABSENT = 2'h2
  } cid_guard_t;
endpackage

/* File: hw/cid_guard_timer.sv */
// Purpose: present/absent guard-time qualification of one tone detector
// Assumes: tick is a one-cycle pulse per guard period
// Notes: limits are compared for equality, so a limit of zero is instant
`timescale 1ns/1ps
module cid_guard_timer #(
  parameter int W = cid_pkg::GUARD_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // control
  input wire logic enable,
  input wire logic tick,
  input wire logic raw,
  input wire logic freqChange,
  input wire logic resetOnChange,
  input wire logic absentPause,
  input wire logic [W-1:0] presentLimit,
  input wire logic [W-1:0] absentLimit,
  // result
  output logic qualified
);
  import cid_pkg::*;

  cid_guard_t state;
  logic [W-1:0] count;
  logic rawPrev;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rawPrev <= 1'h0;
    end else begin
      rawPrev <= raw;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= GT_IDLE;
      count <= '0;
    end else if (!enable) begin
      state <= GT_IDLE;
      count <= '0;
    end else begin
      unique case (state)
        GT_IDLE: begin
          if (raw && !rawPrev) begin
            state <= GT_PRESENT;
            count <= '0;
          end
        end
        GT_PRESENT: begin
          if (!raw) begin
            state <= GT_IDLE;
          end else if (count == presentLimit) begin
            state <= GT_HOLD;
          end else if (resetOnChange && freqChange) begin
            count <= '0;
          end else if (tick) begin
            count <= count + 1'h1;
          end
        end
        GT_HOLD: begin
          if (!raw && rawPrev) begin
            state <= GT_ABSENT;
            count <= '0;
          end
        end
        GT_ABSENT: begin
          if (count == absentLimit) begin
            state <= GT_IDLE;
          end else if (!raw) begin
            if (tick) begin
              count <= count + 1'h1;
            end
          end else if (!absentPause) begin
            if (count == '0) begin
              state <= GT_HOLD;
            end else if (tick) begin
              count <= count - 1'h1;
            end
          end
        end
      endcase
    end
  end

  assign qualified = (state == GT_HOLD) || (state == GT_ABSENT);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence startSeen;
    enable && state == GT_IDLE && raw && !rawPrev;
  endsequence

  guard_start_a: assert property (
    startSeen |=> state == GT_PRESENT && count == '0)
    else $error("guard timer did not restart from zero");
  present_done_a: assert property (
    enable && state == GT_PRESENT && raw && count == presentLimit
    |=> qualified && $stable(count))
    else $error("present limit did not qualify the tone");
  absent_done_a: assert property (
    enable && state == GT_ABSENT && count == absentLimit |=> !qualified)
    else $error("absent limit did not release the tone");
  absent_pause_a: assert property (
    enable && absentPause && state == GT_ABSENT && raw
    && count != absentLimit |=> $stable(count) && qualified)
    else $error("absent counter moved while paused");
endmodule

/* File: verif/cid_detect_ctrl_tb.sv */
// Purpose: self-checking bench of the caller-identity control block
// Assumes: guard tick and carrier counts shortened through parameters
// Notes: all registers are reached through the select/strobe port
`timescale 1ns/1ps
module testbench;
  import cid_pkg::*;
  localparam logic [7:0] BYTE_VAL = 8'hA5;
  localparam logic [7:0] CFG_VAL [NUM_INT] =
    '{8'h01, 8'h10, 8'h99, 8'hA7, 8'h35, 8'h33};
  logic core_clk, rst_b, sfrWrite, sfrRead, ringEnvelope, alertRawDetect;
  logic toneRawDetect, lowBandEnergy, highBandEnergy, fskEnergy, fskBitIn;
  logic fskBitClkIn, fskEn, alertEn, toneEn, commonFlag, toneFreqChange;
  logic [SEL_W-1:0] sfrSel;
  logic [KEY_W-1:0] toneKey;
  logic [DATA_W-1:0] sfrWdata, sfrRdata, rv;
  logic [DATA_W-1:0] cfg [NUM_INT];
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  cid_detect_ctrl #(.TICK_CYCLES(4), .CARRIER_CYC(8)) u_dut (
    .core_clk(core_clk), .rst_b(rst_b), .sfrSel(sfrSel),
    .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata), .ringEnvelope(ringEnvelope),
    .alertRawDetect(alertRawDetect), .toneRawDetect(toneRawDetect),
    .toneKey(toneKey), .toneFreqChange(toneFreqChange),
    .lowBandEnergy(lowBandEnergy), .highBandEnergy(highBandEnergy),
    .fskEnergy(fskEnergy), .fskBitIn(fskBitIn), .fskBitClkIn(fskBitClkIn),
    .fskDecoderEnable(fskEn), .alertDetectEnable(alertEn),
    .dualToneRxEnable(toneEn), .callerCommonFlag(commonFlag),
    .toneRxConfigOne(cfg[0]), .toneRxConfigTwo(cfg[1]),
    .alertFskGain(cfg[2]), .dualToneGain(cfg[3]),
    .alertToneHysteresis(cfg[4]), .fskFilterHysteresis(cfg[5]));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic results;
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results;
    end
  end
  task automatic chk(input string nm, input logic [7:0] got,
                     input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [SEL_W-1:0] s, input logic [7:0] d);
    @(posedge core_clk);
    sfrSel <= s;
    sfrWdata <= d;
    sfrWrite <= 1'b1;
    @(posedge core_clk);
    sfrWrite <= 1'b0;
  endtask
  // reading the fsk byte also pulses the read strobe
  task automatic rd(input logic [SEL_W-1:0] s);
    @(posedge core_clk);
    sfrSel <= s;
    sfrRead <= (s == SEL_FSK_BYTE);
    @(posedge core_clk);
    sfrRead <= 1'b0;
    #1 rv = sfrRdata;
  endtask
  task automatic waitb(input logic [SEL_W-1:0] s, input int b,
                       input logic v);
    rd(s);
    for (int i = 0; i < 60; i++) begin
      if (rv[b] === v) break;
      rd(s);
    end
    chk("status bit", {7'h0, rv[b]}, {7'h0, v});
  endtask
  task automatic sendb(input logic b);
    @(posedge core_clk);
    fskBitIn <= b;
    @(posedge core_clk);
    fskBitClkIn <= 1'b1;
    rd(SEL_STATUS);
    chk("serial", {6'h0, rv[ST_BITCLK], rv[ST_SERIAL]},
        {6'h0, 1'b1, b});
    @(posedge core_clk);
    fskBitClkIn <= 1'b0;
  endtask
  initial begin
    {rst_b, sfrWrite, sfrRead, ringEnvelope, alertRawDetect} = '0;
    {toneRawDetect, lowBandEnergy, highBandEnergy, fskEnergy} = '0;
    {fskBitIn, fskBitClkIn, sfrSel, toneKey, sfrWdata} = '0;
    toneFreqChange = 1'b0;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(SEL_FLAGS);
    chk("flags", rv, 8'h00);
    for (int i = 0; i < 16; i++) begin
      wr(SEL_FSK_BYTE, 8'(i));
      #1 chk("enables", {5'h0, toneEn, alertEn, fskEn},
             i[3] ? 8'(i[2:0]) : 8'h00);
    end
    wr(SEL_FSK_BYTE, 8'h00);
    ringEnvelope <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(SEL_FLAGS);
    chk("ring flags", rv, 8'h81);
    wr(SEL_FLAGS, 8'h00);
    rd(SEL_FLAGS);
    chk("cleared", {rv[7:1], commonFlag}, 8'h00);
    wr(SEL_ALERT_PT, 8'h02);
    wr(SEL_ALERT_AT, 8'h01);
    wr(SEL_FSK_BYTE, 8'h0A);
    alertRawDetect <= 1'b1;
    rd(SEL_STATUS);
    chk("alert early", {7'h0, rv[ST_ALERT]}, 8'h00);
    waitb(SEL_STATUS, ST_ALERT, 1'b1);
    wr(SEL_STATUS, 8'h00);
    rd(SEL_STATUS);
    chk("alert held", {7'h0, rv[ST_ALERT]}, 8'h01);
    alertRawDetect <= 1'b0;
    waitb(SEL_STATUS, ST_ALERT, 1'b0);
    rd(SEL_FLAGS);
    chk("alert flags", rv, 8'h82);
    wr(SEL_FLAGS, 8'h00);
    wr(SEL_TONE_PT, 8'h01);
    wr(SEL_TONE_AT, 8'h01);
    wr(SEL_FSK_BYTE, 8'h0C);
    toneKey <= 4'hB;
    toneRawDetect <= 1'b1;
    waitb(SEL_STATUS, ST_TONE, 1'b1);
    rd(SEL_TONE_RESULT);
    chk("key", {4'h0, rv[3:0]}, 8'h0B);
    toneRawDetect <= 1'b0;
    waitb(SEL_STATUS, ST_TONE, 1'b0);
    rd(SEL_FLAGS);
    chk("tone flags", rv, 8'h84);
    wr(SEL_FLAGS, 8'h00);
    // frequency change resets the present count when config two bit 5 is set
    wr(SEL_GAIN_DATA, 8'h20);
    wr(SEL_GAIN_ADDR, 8'h01);
    wr(SEL_GAIN_ADDR, 8'h11);
    toneFreqChange <= 1'b1;
    toneRawDetect <= 1'b1;
    repeat (40) @(posedge core_clk);
    rd(SEL_STATUS);
    chk("freq change", {7'h0, rv[ST_TONE]}, 8'h00);
    toneFreqChange <= 1'b0;
    waitb(SEL_STATUS, ST_TONE, 1'b1);
    toneRawDetect <= 1'b0;
    waitb(SEL_STATUS, ST_TONE, 1'b0);
    wr(SEL_FLAGS, 8'h00);
    for (int i = 0; i < NUM_INT; i++) begin
      wr(SEL_GAIN_DATA, CFG_VAL[i]);
      wr(SEL_GAIN_ADDR, 8'(i));
      wr(SEL_GAIN_ADDR, 8'(i) | 8'h10);
      @(posedge core_clk);
      #1 chk("config", cfg[i], CFG_VAL[i]);
    end
    @(posedge core_clk);
    lowBandEnergy <= 1'b1;
    rd(SEL_TONE_RESULT);
    chk("low band", rv & 8'h30, 8'h10);
    lowBandEnergy <= 1'b0;
    highBandEnergy <= 1'b1;
    rd(SEL_TONE_RESULT);
    chk("high band", rv & 8'h30, 8'h20);
    wr(SEL_FSK_BYTE, 8'h09);
    fskEnergy <= 1'b1;
    rd(SEL_STATUS);
    chk("carrier early", {7'h0, rv[ST_CARRIER]}, 8'h00);
    waitb(SEL_STATUS, ST_CARRIER, 1'b1);
    sendb(1'b0);
    for (int i = 0; i < 8; i++) sendb(BYTE_VAL[i]);
    waitb(SEL_STATUS, ST_BYTE_READY, 1'b1);
    rd(SEL_FLAGS);
    chk("byte flags", rv, 8'h88);
    rd(SEL_FSK_BYTE);
    chk("fsk byte", rv, BYTE_VAL);
    @(posedge core_clk);
    fskEnergy <= 1'b0;
    waitb(SEL_STATUS, ST_CARRIER, 1'b0);
    results;
  end
endmodule
